// ### rtl/catd_decoder.sv
// Opcode decoder for the arithmetic and data-transfer groups
`timescale 1ns/1ns
`default_nettype none

module catd_decoder (
    input  wire logic                mclk_i,
    input  wire logic                sys_rst_i,
    input  wire catd_pkg::catd_req_t req_i,
    output var  catd_pkg::catd_dec_t dec_o,
    output logic                     dec_valid_o
);
    import catd_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        catd_dec_t dec;
        logic      valid;
    } catd_state_t;

    catd_state_t st;
    catd_state_t next_st;

    logic [7:0] opc;
    logic [1:0] md;
    logic [2:0] rf;
    logic       w;
    logic       mem;

    assign opc = req_i.opcode;
    assign md  = req_i.modrm[MOD_HI:MOD_LO];
    assign rf  = req_i.modrm[REG_HI:REG_LO];
    assign w   = opc[W_BIT];
    assign mem = (md != MOD_REG);

    // ==========================================================
    // Decode
    always_comb begin
        catd_dec_t d;
        logic [7:0] pick_r;
        logic [7:0] pick_m;
        d = '0;
        pick_r = T_RM_R;
        pick_m = T_RM_M;
        d.op       = OP_NONE;
        d.src      = SRC_NONE;
        d.word     = w;
        d.reg_sel  = rf;
        if ((opc & M_FC) == P_SUM_RM || (opc & M_FC) == P_ADC_RM ||
            (opc & M_FC) == P_SUB_RM || (opc & M_FC) == P_SBB_RM ||
            (opc & M_FC) == P_CMP_RM) begin
            case (opc & M_FC)
                P_SUM_RM: d.op = OP_SUM;
                P_ADC_RM: d.op = OP_SUM_CARRY;
                P_SUB_RM: d.op = OP_DIFF;
                P_SBB_RM: d.op = OP_DIFF_BORROW;
                default:  d.op = OP_COMPARE;
            endcase
            d.src    = SRC_MODRM;
            d.to_reg = opc[DS_BIT];
            d.mem    = mem;
            // Memory form first, register second
            d.clk_min = mem ? T_RM_M : T_RM_R;
        end else if ((opc & M_FE) == P_SUM_ACC ||
                     (opc & M_FE) == P_ADC_ACC ||
                     (opc & M_FE) == P_SUB_ACC ||
                     (opc & M_FE) == P_SBB_ACC ||
                     (opc & M_FE) == P_CMP_ACC) begin
            case (opc & M_FE)
                P_SUM_ACC: d.op = OP_SUM;
                P_ADC_ACC: d.op = OP_SUM_CARRY;
                P_SUB_ACC: d.op = OP_DIFF;
                P_SBB_ACC: d.op = OP_DIFF_BORROW;
                default:   d.op = OP_COMPARE;
            endcase
            d.src       = SRC_IMM;
            d.acc_dest  = 1'b1;
            d.imm_bytes = w ? 2'h2 : 2'h1;
            d.clk_min   = w ? T_ACC_W : T_ACC_B;
        end else if ((opc & M_FC) == P_IMM_GRP) begin
            d.src      = SRC_IMM;
            d.mem      = mem;
            // s=1 with w=1 takes one byte, widened by sign
            d.sign_ext = opc[DS_BIT] & w;
            d.imm_bytes = (w && !opc[DS_BIT]) ? 2'h2 : 2'h1;
            d.clk_min  = mem ? T_IMM_M : T_IMM_R;
            case (rf)
                GRP_SUM:    d.op = OP_SUM;
                GRP_CARRY:  d.op = OP_SUM_CARRY;
                GRP_BORROW: d.op = OP_DIFF_BORROW;
                GRP_DIFF:   d.op = OP_DIFF;
                GRP_CMP: begin
                    d.op      = OP_COMPARE;
                    d.clk_min = mem ? T_RM_M : T_RM_R;
                end
                default: begin
                    d.illegal = 1'b1;
                    d.src     = SRC_NONE;
                    d.clk_min = '0;
                end
            endcase
        end else if ((opc & M_FE) == P_MULDIV) begin
            d.src = SRC_MODRM;
            d.mem = mem;
            case (rf)
                GRP_UPROD: begin
                    d.op = OP_UPROD;
                    pick_r = w ? T_UP_RW_LO : T_UP_RB_LO;
                    pick_m = w ? T_UP_MW_LO : T_UP_MB_LO;
                    d.clk_min = mem ? pick_m : pick_r;
                    pick_r = w ? T_UP_RW_HI : T_UP_RB_HI;
                    pick_m = w ? T_UP_MW_HI : T_UP_MB_HI;
                    d.clk_max = mem ? pick_m : pick_r;
                end
                GRP_SPROD: begin
                    d.op = OP_SPROD;
                    pick_r = w ? T_SP_RW_LO : T_SP_RB_LO;
                    pick_m = w ? T_SP_MW_LO : T_SP_MB_LO;
                    d.clk_min = mem ? pick_m : pick_r;
                    pick_r = w ? T_SP_RW_HI : T_SP_RB_HI;
                    pick_m = w ? T_SP_MW_HI : T_SP_MB_HI;
                    d.clk_max = mem ? pick_m : pick_r;
                end
                GRP_UQUOT: begin
                    d.op = OP_UQUOT;
                    pick_r = w ? T_UQ_RW : T_UQ_RB;
                    pick_m = w ? T_UQ_MW : T_UQ_MB;
                    d.clk_min = mem ? pick_m : pick_r;
                end
                default: begin
                    // Other members of this group are outside this block
                    d.illegal = 1'b1;
                    d.src     = SRC_NONE;
                end
            endcase
        end else if ((opc & M_FD) == P_SPROD_I) begin
            d.op        = OP_SPROD_IMM;
            d.src       = SRC_IMM;
            d.mem       = mem;
            d.word      = 1'b1;
            d.to_reg    = 1'b1;
            d.sign_ext  = opc[DS_BIT];
            d.imm_bytes = opc[DS_BIT] ? 2'h1 : 2'h2;
            d.clk_min   = mem ? T_SPI_M_LO : T_SPI_R_LO;
            d.clk_max   = mem ? T_SPI_M_HI : T_SPI_R_HI;
        end else if ((opc & M_F8) == P_XCHG_ACC) begin
            d.op       = OP_XCHG_ACC;
            d.word     = 1'b1;
            d.acc_dest = 1'b1;
            d.reg_sel  = opc[2:0];
            d.clk_min  = T_XCHG;
        end else if ((opc & M_FE) == P_IN_FIX ||
                     (opc & M_FE) == P_IN_VAR) begin
            d.op       = OP_PORT_IN;
            d.acc_dest = 1'b1;
            d.imm_bytes = ((opc & M_FE) == P_IN_FIX) ? 2'h1 : 2'h0;
            d.src      = ((opc & M_FE) == P_IN_FIX) ? SRC_IMM : SRC_NONE;
            d.clk_min  = ((opc & M_FE) == P_IN_FIX) ? T_IN_FIX : T_IN_VAR;
        end else if ((opc & M_FE) == P_OUT_FIX ||
                     (opc & M_FE) == P_OUT_VAR) begin
            d.op       = OP_PORT_OUT;
            d.imm_bytes = ((opc & M_FE) == P_OUT_FIX) ? 2'h1 : 2'h0;
            d.src      = ((opc & M_FE) == P_OUT_FIX) ? SRC_IMM : SRC_NONE;
            d.clk_min  = ((opc & M_FE) == P_OUT_FIX) ? T_OUT_FIX
                                                     : T_OUT_VAR;
        end else begin
            d.word = 1'b0;
            case (opc)
                OPC_BCD_SUM: begin
                    d.op = OP_BCD_SUM;
                    d.clk_min = T_BCD_S;
                end
                OPC_PACK_SUM: begin
                    d.op = OP_PACK_SUM;
                    d.clk_min = T_PACK;
                end
                OPC_BCD_DIFF: begin
                    d.op = OP_BCD_DIFF;
                    d.clk_min = T_BCD_D;
                end
                OPC_PACK_DIFF: begin
                    d.op = OP_PACK_DIFF;
                    d.clk_min = T_PACK;
                end
                OPC_TABLE: begin
                    d.op = OP_TABLE_LOOK;
                    d.acc_dest = 1'b1;
                    d.mem = 1'b1;
                    d.clk_min = T_TABLE;
                end
                OPC_EA_LOAD: begin
                    // Destination gets the offset, no memory read
                    d.op = OP_EA_LOAD;
                    d.src = SRC_MODRM;
                    d.word = 1'b1;
                    d.to_reg = 1'b1;
                    d.clk_min = T_EA;
                end
                OPC_FAR_DS, OPC_FAR_ES: begin
                    d.op = (opc == OPC_FAR_DS) ? OP_FAR_DS
                                               : OP_FAR_ES;
                    d.src = SRC_MODRM;
                    d.word = 1'b1;
                    d.to_reg = 1'b1;
                    d.mem = 1'b1;
                    // Register operand has no defined meaning here
                    d.illegal = !mem;
                    d.clk_min = T_FAR;
                end
                OPC_FL_TO_AH: begin
                    d.op = OP_FLAGS_TO_AH;
                    d.clk_min = T_FL_AH;
                end
                OPC_AH_TO_FL: begin
                    d.op = OP_AH_TO_FLAGS;
                    d.clk_min = T_AH_FL;
                end
                default: d.illegal = 1'b1;
            endcase
        end
        // Bus handshake may stretch memory forms by up to two clocks
        if (d.clk_max == '0 && !d.illegal) begin
            d.clk_max = d.mem ? 8'(d.clk_min + T_MEM_SLACK)
                              : d.clk_min;
        end
        next_st.dec   = d;
        next_st.valid = req_i.valid;
        if (sys_rst_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        st <= next_st;
    end

    assign dec_o       = st.dec;
    assign dec_valid_o = st.valid;

endmodule

`default_nettype wire

// ### rtl/catd_pkg.sv
// Package for the arithmetic and transfer opcode decoder: codes and timings
package catd_pkg;

    // ==========================================================
    // Operation classes
    typedef enum logic [4:0] {
        OP_NONE       = 5'h00,
        OP_SUM        = 5'h01,
        OP_SUM_CARRY  = 5'h02,
        OP_DIFF       = 5'h03,
        OP_DIFF_BORROW= 5'h04,
        OP_COMPARE    = 5'h05,
        OP_BCD_SUM    = 5'h06,
        OP_PACK_SUM   = 5'h07,
        OP_BCD_DIFF   = 5'h08,
        OP_PACK_DIFF  = 5'h09,
        OP_UPROD      = 5'h0a,
        OP_SPROD      = 5'h0b,
        OP_SPROD_IMM  = 5'h0c,
        OP_UQUOT      = 5'h0d,
        OP_EA_LOAD    = 5'h0e,
        OP_FAR_DS     = 5'h0f,
        OP_FAR_ES     = 5'h10,
        OP_FLAGS_TO_AH= 5'h11,
        OP_AH_TO_FLAGS= 5'h12,
        OP_TABLE_LOOK = 5'h13,
        OP_XCHG_ACC   = 5'h14,
        OP_PORT_IN    = 5'h15,
        OP_PORT_OUT   = 5'h16
    } catd_op_t;

    // Operand source of the second operand
    typedef enum logic [1:0] {
        SRC_MODRM = 2'h0,
        SRC_IMM   = 2'h1,
        SRC_NONE  = 2'h2
    } catd_src_t;

    typedef struct packed {
        catd_op_t  op;
        catd_src_t src;
        logic      word;
        logic      sign_ext;
        logic      to_reg;
        logic      mem;
        logic      acc_dest;
        logic      illegal;
        logic [1:0] imm_bytes;
        logic [2:0] reg_sel;
        logic [7:0] clk_min;
        logic [7:0] clk_max;
    } catd_dec_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] modrm;
    } catd_req_t;

    // ==========================================================
    // Field positions
    localparam int W_BIT   = 0;
    localparam int DS_BIT  = 1;
    localparam int MOD_HI  = 7;
    localparam int MOD_LO  = 6;
    localparam int REG_HI  = 5;
    localparam int REG_LO  = 3;
    localparam logic [1:0] MOD_REG = 2'h3;

    // Opcode patterns under masks
    localparam logic [7:0] M_FC = 8'hfc;
    localparam logic [7:0] M_FE = 8'hfe;
    localparam logic [7:0] M_FD = 8'hfd;
    localparam logic [7:0] M_F8 = 8'hf8;
    localparam logic [7:0] P_SUM_RM   = 8'h00;
    localparam logic [7:0] P_SUM_ACC  = 8'h04;
    localparam logic [7:0] P_ADC_RM   = 8'h10;
    localparam logic [7:0] P_ADC_ACC  = 8'h14;
    localparam logic [7:0] P_SUB_RM   = 8'h28;
    localparam logic [7:0] P_SUB_ACC  = 8'h2c;
    localparam logic [7:0] P_SBB_RM   = 8'h18;
    localparam logic [7:0] P_SBB_ACC  = 8'h1c;
    localparam logic [7:0] P_CMP_RM   = 8'h38;
    localparam logic [7:0] P_CMP_ACC  = 8'h3c;
    localparam logic [7:0] P_IMM_GRP  = 8'h80;
    localparam logic [7:0] P_MULDIV   = 8'hf6;
    localparam logic [7:0] P_SPROD_I  = 8'h69;
    localparam logic [7:0] P_XCHG_ACC = 8'h90;
    localparam logic [7:0] P_IN_FIX   = 8'he4;
    localparam logic [7:0] P_IN_VAR   = 8'hec;
    localparam logic [7:0] P_OUT_FIX  = 8'he6;
    localparam logic [7:0] P_OUT_VAR  = 8'hee;
    localparam logic [7:0] OPC_BCD_SUM   = 8'h37;
    localparam logic [7:0] OPC_PACK_SUM  = 8'h27;
    localparam logic [7:0] OPC_BCD_DIFF  = 8'h3f;
    localparam logic [7:0] OPC_PACK_DIFF = 8'h2f;
    localparam logic [7:0] OPC_TABLE     = 8'hd7;
    localparam logic [7:0] OPC_EA_LOAD   = 8'h8d;
    localparam logic [7:0] OPC_FAR_DS    = 8'hc5;
    localparam logic [7:0] OPC_FAR_ES    = 8'hc4;
    localparam logic [7:0] OPC_FL_TO_AH  = 8'h9f;
    localparam logic [7:0] OPC_AH_TO_FL  = 8'h9e;

    // Immediate group and multiply/divide group reg fields
    localparam logic [2:0] GRP_SUM   = 3'h0;
    localparam logic [2:0] GRP_CARRY = 3'h2;
    localparam logic [2:0] GRP_BORROW= 3'h3;
    localparam logic [2:0] GRP_DIFF  = 3'h5;
    localparam logic [2:0] GRP_CMP   = 3'h7;
    localparam logic [2:0] GRP_UPROD = 3'h4;
    localparam logic [2:0] GRP_SPROD = 3'h5;
    localparam logic [2:0] GRP_UQUOT = 3'h6;

    // ==========================================================
    // Clock counts, minimum and for ranges maximum (register / memory forms)
    localparam logic [7:0] T_RM_R   = 8'd3;
    localparam logic [7:0] T_RM_M   = 8'd10;
    localparam logic [7:0] T_IMM_R  = 8'd4;
    localparam logic [7:0] T_IMM_M  = 8'd16;
    localparam logic [7:0] T_ACC_B  = 8'd3;
    localparam logic [7:0] T_ACC_W  = 8'd4;
    localparam logic [7:0] T_BCD_S  = 8'd8;
    localparam logic [7:0] T_PACK   = 8'd4;
    localparam logic [7:0] T_BCD_D  = 8'd7;
    localparam logic [7:0] T_UP_RB_LO = 8'd26;
    localparam logic [7:0] T_UP_RB_HI = 8'd28;
    localparam logic [7:0] T_UP_RW_LO = 8'd35;
    localparam logic [7:0] T_UP_RW_HI = 8'd37;
    localparam logic [7:0] T_UP_MB_LO = 8'd32;
    localparam logic [7:0] T_UP_MB_HI = 8'd34;
    localparam logic [7:0] T_UP_MW_LO = 8'd41;
    localparam logic [7:0] T_UP_MW_HI = 8'd43;
    localparam logic [7:0] T_SP_RB_LO = 8'd25;
    localparam logic [7:0] T_SP_RB_HI = 8'd28;
    localparam logic [7:0] T_SP_RW_LO = 8'd34;
    localparam logic [7:0] T_SP_RW_HI = 8'd37;
    localparam logic [7:0] T_SP_MB_LO = 8'd31;
    localparam logic [7:0] T_SP_MB_HI = 8'd34;
    localparam logic [7:0] T_SP_MW_LO = 8'd40;
    localparam logic [7:0] T_SP_MW_HI = 8'd43;
    localparam logic [7:0] T_SPI_R_LO = 8'd22;
    localparam logic [7:0] T_SPI_R_HI = 8'd25;
    localparam logic [7:0] T_SPI_M_LO = 8'd29;
    localparam logic [7:0] T_SPI_M_HI = 8'd32;
    localparam logic [7:0] T_UQ_RB  = 8'd29;
    localparam logic [7:0] T_UQ_RW  = 8'd38;
    localparam logic [7:0] T_UQ_MB  = 8'd35;
    localparam logic [7:0] T_UQ_MW  = 8'd44;
    localparam logic [7:0] T_EA     = 8'd6;
    localparam logic [7:0] T_FAR    = 8'd18;
    localparam logic [7:0] T_FL_AH  = 8'd2;
    localparam logic [7:0] T_AH_FL  = 8'd3;
    localparam logic [7:0] T_TABLE  = 8'd11;
    localparam logic [7:0] T_XCHG   = 8'd3;
    localparam logic [7:0] T_IN_FIX = 8'd10;
    localparam logic [7:0] T_IN_VAR = 8'd8;
    localparam logic [7:0] T_OUT_FIX= 8'd9;
    localparam logic [7:0] T_OUT_VAR= 8'd7;
    // Slack a memory form may add over its minimum
    localparam logic [7:0] T_MEM_SLACK = 8'd2;

endpackage

// ### testbench/catd_decoder_monitor.sv
// Concurrent checks on the ports of the arithmetic and transfer decoder
`timescale 1ns/1ns
`default_nettype none

module catd_decoder_monitor (
    input wire logic                mclk_i,
    input wire logic                sys_rst_i,
    input wire catd_pkg::catd_req_t req_i,
    input wire catd_pkg::catd_dec_t dec_o,
    input wire logic                dec_valid_o
);
    import catd_pkg::*;

    // ==========================================================
    // Request seen one edge earlier, since the answer lags by one cycle
    logic       p_val;
    logic       p_rst;
    logic [7:0] p_opc;
    logic [7:0] p_mrm;
    always_ff @(posedge mclk_i) begin
        p_val <= req_i.valid;
        p_rst <= sys_rst_i;
        p_opc <= req_i.opcode;
        p_mrm <= req_i.modrm;
    end
    // The edge right after reset answers the reset, not a request
    wire logic       live  = p_val && !p_rst;
    wire logic       p_mem = p_mrm[7:6] != 2'h3;
    wire logic [2:0] p_reg = p_mrm[5:3];
    wire logic [7:0] t_rm  = p_mem ? 8'h0a : 8'h03;
    wire logic [7:0] t_imm = p_mem ? 8'h10 : 8'h04;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    valid_echo_a: assert property (
        !$past(sys_rst_i) |-> dec_valid_o == $past(req_i.valid))
        else $error("answer valid does not follow the request");
    idle_quiet_a: assert property (
        !req_i.valid ##1 !req_i.valid |-> !dec_valid_o ##1 !dec_valid_o)
        else $error("answer valid without a request");
    sum_reg_a: assert property (
        live && (p_opc & 8'hfc) == 8'h00
        |-> dec_o.op == OP_SUM && dec_o.clk_min == t_rm)
        else $error("register sum decoded wrongly");
    imm_grp_a: assert property (
        live && (p_opc & 8'hfc) == 8'h80 && p_reg inside {3'h0, 3'h2, 3'h7}
        |-> dec_o.clk_min == (p_reg == 3'h7 ? t_rm : t_imm))
        else $error("immediate group count wrong");
    acc_sum_a: assert property (
        live && (p_opc & 8'hfe) == 8'h04
        |-> dec_o.clk_min == (p_opc[0] ? 8'h04 : 8'h03)
            && dec_o.imm_bytes == {p_opc[0], !p_opc[0]})
        else $error("accumulator sum decoded wrongly");
    adjust_a: assert property (
        live && p_opc inside {8'h37, 8'h27, 8'h3f, 8'h2f}
        |-> dec_o.clk_min == (p_opc == 8'h37 ? 8'h08
                            : p_opc == 8'h3f ? 8'h07 : 8'h04))
        else $error("adjust count wrong");
    far_ptr_a: assert property (
        live && (p_opc & 8'hfe) == 8'hc4
        |-> dec_o.clk_min == 8'h12 && dec_o.illegal == !p_mem)
        else $error("far pointer load decoded wrongly");
    flag_move_a: assert property (
        live && (p_opc & 8'hfe) == 8'h9e
        |-> dec_o.clk_min == (p_opc[0] ? 8'h02 : 8'h03))
        else $error("flag byte move count wrong");
    product_a: assert property (
        live && p_opc == 8'hf7 && p_mem && p_reg[2:1] == 2'h2
        |-> dec_o.clk_min == (p_reg[0] ? 8'h28 : 8'h29)
            && dec_o.clk_max == 8'h2b)
        else $error("memory word product range wrong");
    imm_prod_a: assert property (
        live && (p_opc & 8'hfd) == 8'h69
        |-> dec_o.clk_min == (p_mem ? 8'h1d : 8'h16)
            && dec_o.clk_max == (p_mem ? 8'h20 : 8'h19))
        else $error("immediate product range wrong");
    quot_a: assert property (
        live && p_opc[7:1] == 7'h7b && p_reg == 3'h6 && !(p_mem && !p_opc[0])
        |-> dec_o.clk_min == (p_mem ? 8'h2c : p_opc[0] ? 8'h26 : 8'h1d))
        else $error("quotient count wrong");

    cover property (live && p_mem && (p_opc & 8'hfc) == 8'h00);
    cover property (dec_valid_o && dec_o.illegal);
    cover property (dec_valid_o [*2]);
endmodule

bind catd_decoder catd_decoder_monitor catd_decoder_monitor_inst (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .req_i       (req_i),
    .dec_o       (dec_o),
    .dec_valid_o (dec_valid_o)
);
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the arithmetic and transfer decoder
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import catd_pkg::*;
    logic      mclk_i;
    logic      sys_rst_i;
    catd_req_t req_i;
    catd_dec_t dec_o;
    logic      dec_valid_o;
    int        error_cnt;
    int        n_compared;

    catd_decoder catd_decoder_inst (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .req_i       (req_i),
        .dec_o       (dec_o),
        .dec_valid_o (dec_valid_o)
    );

    always #5 mclk_i = ~mclk_i;

    // ==========================================================
    // Compare and drive helpers
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_op(input catd_op_t got, input catd_op_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, answer sampled just after the edge that registers it
    task automatic expect_dec(input logic [7:0] opc, input logic [7:0] mrm,
        input catd_op_t op, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge mclk_i);
        req_i <= '{valid: 1'b1, opcode: opc, modrm: mrm};
        @(posedge mclk_i);
        req_i <= '0;
        #1;
        check_val({7'h0, dec_valid_o}, 8'h01);
        check_op(dec_o.op, op);
        check_val(dec_o.clk_min, lo);
        // Zero skips the maximum where no range is fixed
        if (hi != 8'h00) check_val(dec_o.clk_max, hi);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_sum;
        expect_dec(8'h00, 8'hc0, OP_SUM, 8'h03, 8'h03);
        expect_dec(8'h03, 8'h06, OP_SUM, 8'h0a, 8'h0c);
        expect_dec(8'h04, 8'h00, OP_SUM, 8'h03, 8'h03);
        check_val({6'h0, dec_o.imm_bytes}, 8'h01);
        expect_dec(8'h05, 8'h00, OP_SUM, 8'h04, 8'h04);
        check_val({6'h0, dec_o.imm_bytes}, 8'h02);
        expect_dec(8'h14, 8'h00, OP_SUM_CARRY, 8'h03, 8'h03);
        expect_dec(8'h15, 8'h00, OP_SUM_CARRY, 8'h04, 8'h04);
    endtask
    task automatic t_imm_group;
        logic [2:0] grp [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
        catd_op_t   ops [5] = '{OP_SUM, OP_SUM_CARRY, OP_DIFF_BORROW,
                               OP_DIFF, OP_COMPARE};
        logic [7:0] tr;
        logic [7:0] tm;
        for (int i = 0; i < 5; i++) begin
            tr = (grp[i] == 3'h7) ? 8'h03 : 8'h04;
            tm = (grp[i] == 3'h7) ? 8'h0a : 8'h10;
            expect_dec(8'h81, {2'h3, grp[i], 3'h1}, ops[i], tr, tr);
            check_val({6'h0, dec_o.imm_bytes}, 8'h02);
            expect_dec(8'h83, {2'h0, grp[i], 3'h6}, ops[i], tm, tm + 8'h02);
            check_val({6'h0, dec_o.word, dec_o.sign_ext}, 8'h03);
            check_val({6'h0, dec_o.imm_bytes}, 8'h01);
        end
        expect_dec(8'h80, 8'hd0, OP_SUM_CARRY, 8'h04, 8'h04);
        check_val({6'h0, dec_o.word, dec_o.sign_ext}, 8'h00);
    endtask
    task automatic t_diff_cmp;
        expect_dec(8'h2a, 8'hc1, OP_DIFF, 8'h03, 8'h03);
        expect_dec(8'h29, 8'h06, OP_DIFF, 8'h0a, 8'h0c);
        expect_dec(8'h2c, 8'h00, OP_DIFF, 8'h03, 8'h03);
        expect_dec(8'h2d, 8'h00, OP_DIFF, 8'h04, 8'h04);
        expect_dec(8'h1a, 8'hc2, OP_DIFF_BORROW, 8'h03, 8'h03);
        expect_dec(8'h19, 8'h46, OP_DIFF_BORROW, 8'h0a, 8'h0c);
        expect_dec(8'h1c, 8'h00, OP_DIFF_BORROW, 8'h03, 8'h03);
        expect_dec(8'h1d, 8'h00, OP_DIFF_BORROW, 8'h04, 8'h04);
        expect_dec(8'h3a, 8'hc3, OP_COMPARE, 8'h03, 8'h03);
        expect_dec(8'h3b, 8'h86, OP_COMPARE, 8'h0a, 8'h0c);
    endtask
    task automatic t_adjust;
        expect_dec(8'h37, 8'h00, OP_BCD_SUM, 8'h08, 8'h08);
        expect_dec(8'h27, 8'h00, OP_PACK_SUM, 8'h04, 8'h04);
        expect_dec(8'h3f, 8'h00, OP_BCD_DIFF, 8'h07, 8'h07);
        expect_dec(8'h2f, 8'h00, OP_PACK_DIFF, 8'h04, 8'h04);
    endtask
    task automatic t_products;
        expect_dec(8'hf7, 8'h26, OP_UPROD, 8'h29, 8'h2b);
        expect_dec(8'hf7, 8'h2e, OP_SPROD, 8'h28, 8'h2b);
        expect_dec(8'h69, 8'hc8, OP_SPROD_IMM, 8'h16, 8'h19);
        check_val({6'h0, dec_o.imm_bytes}, 8'h02);
        expect_dec(8'h6b, 8'h0e, OP_SPROD_IMM, 8'h1d, 8'h20);
        check_val({6'h0, dec_o.imm_bytes}, 8'h01);
        expect_dec(8'hf6, 8'hf1, OP_UQUOT, 8'h1d, 8'h1d);
        expect_dec(8'hf7, 8'hf1, OP_UQUOT, 8'h26, 8'h26);
        expect_dec(8'hf7, 8'h36, OP_UQUOT, 8'h2c, 8'h2e);
    endtask
    task automatic t_transfers;
        expect_dec(8'h8d, 8'h1e, OP_EA_LOAD, 8'h06, 8'h00);
        check_val({5'h0, dec_o.reg_sel}, 8'h03);
        expect_dec(8'hc5, 8'h16, OP_FAR_DS, 8'h12, 8'h00);
        check_val({7'h0, dec_o.illegal}, 8'h00);
        expect_dec(8'hc5, 8'hd0, OP_FAR_DS, 8'h12, 8'h00);
        check_val({7'h0, dec_o.illegal}, 8'h01);
        expect_dec(8'hc4, 8'h06, OP_FAR_ES, 8'h12, 8'h00);
        check_val({7'h0, dec_o.illegal}, 8'h00);
        expect_dec(8'h9f, 8'h00, OP_FLAGS_TO_AH, 8'h02, 8'h02);
        expect_dec(8'h9e, 8'h00, OP_AH_TO_FLAGS, 8'h03, 8'h03);
        expect_dec(8'hd7, 8'h00, OP_TABLE_LOOK, 8'h0b, 8'h0d);
        check_val({7'h0, dec_o.mem}, 8'h01);
        expect_dec(8'he4, 8'h00, OP_PORT_IN, 8'h0a, 8'h0a);
        expect_dec(8'hed, 8'h00, OP_PORT_IN, 8'h08, 8'h08);
        expect_dec(8'he6, 8'h00, OP_PORT_OUT, 8'h09, 8'h09);
        expect_dec(8'hef, 8'h00, OP_PORT_OUT, 8'h07, 8'h07);
        expect_dec(8'h93, 8'h00, OP_XCHG_ACC, 8'h03, 8'h03);
        check_val({5'h0, dec_o.reg_sel}, 8'h03);
        expect_dec(8'h3c, 8'h00, OP_COMPARE, 8'h03, 8'h03);
        expect_dec(8'h3d, 8'h00, OP_COMPARE, 8'h04, 8'h04);
    endtask
    // Two requests on adjacent edges must give two separate answers
    task automatic t_back_to_back;
        @(posedge mclk_i);
        req_i <= '{valid: 1'b1, opcode: 8'h00, modrm: 8'hc0};
        @(posedge mclk_i);
        req_i <= '{valid: 1'b1, opcode: 8'h9f, modrm: 8'h00};
        #1;
        check_op(dec_o.op, OP_SUM);
        check_val(dec_o.clk_min, 8'h03);
        @(posedge mclk_i);
        req_i <= '0;
        #1;
        check_op(dec_o.op, OP_FLAGS_TO_AH);
        check_val(dec_o.clk_min, 8'h02);
        @(posedge mclk_i);
        #1;
        check_val({7'h0, dec_valid_o}, 8'h00);
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        sys_rst_i = 1'b1;
        req_i = '0;
        error_cnt = 0;
        n_compared = 0;
        repeat (20) @(posedge mclk_i);
        #1;
        check_val({7'h0, dec_valid_o}, 8'h00);
        check_op(dec_o.op, OP_NONE);
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_sum();
        t_imm_group();
        t_diff_cmp();
        t_adjust();
        t_products();
        t_transfers();
        t_back_to_back();
        stop_test();
    end
endmodule
`default_nettype wire
